// file: bench/codec_gain_and_dsp_config_sva.sv
// Concurrent checks on the gain and DSP setup bank ports
`timescale 1ns/1ps

module codec_cfg_sva
    import codec_cfg_pkg::*;
(
    // Clock and reset
    input wire logic                              i_ref_clk,
    input wire logic                              i_reset_n,
    // Host port
    input wire host_req_t                         i_host_req,
    input wire logic [7:0]                        o_rd_data,
    input wire logic                              o_rd_valid,
    // Decoded outputs
    input wire logic                              o_ch2b_mute,
    input wire logic signed [8:0]                 o_ch2b_gain_half_db,
    input wire logic signed [4:0]                 o_ch2b_trim_tenth_db,
    input wire record_dsp_setup_t                 o_record_setup,
    input wire logic                              o_highpass_custom,
    input wire logic [2:0]                        o_record_biquad_enable,
    input wire logic [RECORD_CHANNELS-1:0][7:0]   o_record_digital_level,
    input wire logic [RECORD_CHANNELS-1:0]        o_record_ramping
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    ////////////////////////////////////////////////////////////////////////
    // Masked write to one register
    sequence s_wr(logic [7:0] a, logic [7:0] m, logic [7:0] v);
        i_host_req.wr_en && i_host_req.addr == a
            && (i_host_req.wr_data & m) == v;
    endsequence
    sequence s_rd(logic [7:0] a);
        i_host_req.rd_en && i_host_req.addr == a;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_mute_on_zero: assert property (
        s_wr(OFS_PLAYBACK_CH2B_VOLUME, 8'hff, 8'h00) |-> ##2 o_ch2b_mute)
        else $error("volume code zero did not mute");
    a_unity_gain: assert property (
        s_wr(OFS_PLAYBACK_CH2B_VOLUME, 8'hff, 8'hc9) |-> ##2
            (o_ch2b_gain_half_db == 9'sh000 && !o_ch2b_mute))
        else $error("unity code not decoded as 0 dB");
    a_trim_neutral: assert property (
        s_wr(OFS_PLAYBACK_CH2B_TRIM, 8'hf0, 8'h80) |-> ##2
            o_ch2b_trim_tenth_db == 5'sh00)
        else $error("neutral trim code not 0 dB");
    a_trim_low_zero: assert property (
        s_rd(OFS_PLAYBACK_CH2B_TRIM) |=> o_rd_data[3:0] == 4'h0)
        else $error("reserved trim bits read nonzero");
    // Back-to-back reads are legal, so valid follows rd_en edge by edge
    a_read_pulse: assert property (
        i_host_req.rd_en |=> o_rd_valid)
        else $error("read valid missing after a read");
    a_read_idle: assert property (
        !i_host_req.rd_en |=> !o_rd_valid)
        else $error("read valid without a read");
    a_decim_hold: assert property (
        s_wr(OFS_RECORD_DSP_SETUP, 8'hc0, 8'hc0) |=>
            $stable(o_record_setup.record_decim_response))
        else $error("forbidden decimation value was taken");
    a_highpass_custom: assert property (
        s_wr(OFS_RECORD_DSP_SETUP, 8'h30, 8'h00) |-> ##2 o_highpass_custom)
        else $error("highpass choice zero not custom");
    a_biquad_full: assert property (
        s_wr(OFS_RECORD_DSP_SETUP, 8'h0c, 8'h0c) |-> ##2
            o_record_biquad_enable == 3'h7)
        else $error("three biquads not all enabled");
    a_bypass_still: assert property (
        o_record_setup.ramp_bypass [*3] |-> o_record_ramping == 4'h0)
        else $error("ramp moving while bypassed");
    a_ramp_step: assert property (
        !o_record_setup.ramp_bypass && !$past(o_record_setup.ramp_bypass)
        |-> 8'(o_record_digital_level[1] - $past(o_record_digital_level[1]))
            inside {8'h00, 8'h01, 8'hff})
        else $error("ramped level jumped more than one code");
endmodule

// file: bench/codec_gain_and_dsp_config_tb.sv
// Self-checking bench for the gain and DSP setup bank
`timescale 1ns/1ps

`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module codec_gain_and_dsp_config_tb;
    import codec_cfg_pkg::*;
    localparam int STEP = 2;

    logic                                 i_ref_clk;
    logic                                 i_reset_n;
    host_req_t                            req;
    logic [RECORD_CHANNELS-1:0][7:0]      vol;
    logic [RECORD_CHANNELS-1:0]           act;
    logic [7:0]                           rd_data;
    logic                                 rd_valid;
    logic                                 mute;
    logic signed [8:0]                    gain;
    logic signed [4:0]                    trim;
    record_dsp_setup_t                    setup;
    logic                                 custom;
    logic [2:0]                           bq;
    logic [RECORD_CHANNELS-1:0][7:0]      lvl;
    logic [RECORD_CHANNELS-1:0]           ramping;
    int                                   error_cnt = 0;
    int                                   tests_run = 0;
    // Volume codes and gains in 0.5 dB units, mute reads as zero gain
    logic [7:0]        vc [8] = '{8'h00, 8'h01, 8'h02, 8'hc9,
                                  8'hca, 8'hfe, 8'hff, 8'h64};
    logic signed [8:0] vg [8] = '{9'h000, 9'h138, 9'h139, 9'h000,
                                  9'h001, 9'h035, 9'h036, 9'h19b};
    // Setup writes, read-back, custom flag, biquad enables
    logic [7:0]        sw [4] = '{8'h40, 8'h94, 8'hec, 8'h38};
    logic [7:0]        sr [4] = '{8'h40, 8'h94, 8'hac, 8'h38};
    logic              sc [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    logic [2:0]        sb [4] = '{3'h0, 3'h1, 3'h7, 3'h3};

    codec_gain_and_dsp_config #(.STEP_CYCLES(STEP)) i_dut (
        .i_ref_clk                   (i_ref_clk),
        .i_reset_n                   (i_reset_n),
        .i_host_req                  (req),
        .o_rd_data                   (rd_data),
        .o_rd_valid                  (rd_valid),
        .i_record_per_channel_volume (vol),
        .i_record_channel_active     (act),
        .o_ch2b_mute                 (mute),
        .o_ch2b_gain_half_db         (gain),
        .o_ch2b_trim_tenth_db        (trim),
        .o_record_setup              (setup),
        .o_highpass_custom           (custom),
        .o_record_biquad_enable      (bq),
        .o_record_digital_level      (lvl),
        .o_record_ramping            (ramping)
    );

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // Every task starts and ends just after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.wr_en   = 1'b1;
        req.addr    = a;
        req.wr_data = d;
        tick(1);
        req.wr_en   = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        req.rd_en = 1'b1;
        req.addr  = a;
        tick(1);
        req.rd_en = 1'b0;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, e)
        // Idle edge so a following read does not retoggle rd_en at once
        tick(1);
    endtask

    task automatic wrap_up;
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        req       = '0;
        vol       = {4{8'hc9}};
        act       = 4'hf;
        i_reset_n = 1'b0;
        tick(2);
        i_reset_n = 1'b1;
        rd_chk(OFS_PLAYBACK_CH2B_VOLUME, 8'hc9);
        rd_chk(OFS_PLAYBACK_CH2B_TRIM, 8'h80);
        rd_chk(OFS_RECORD_DSP_SETUP, 8'h18);
        `CHK(bq, 3'h3)
        `CHK(custom, 1'b0)
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_PLAYBACK_CH2B_VOLUME, vc[i]);
            tick(1);
            `CHK(mute, vc[i] == 8'h00)
            `CHK(gain, vg[i])
        end
        // Every trim code, reserved nibble always written as zeros
        for (int i = 0; i < 16; i++)
        begin
            wr(OFS_PLAYBACK_CH2B_TRIM, {4'(i), 4'h0});
            tick(1);
            `CHK(trim, 5'(i - 8))
            rd_chk(OFS_PLAYBACK_CH2B_TRIM, {4'(i), 4'h0});
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_RECORD_DSP_SETUP, sw[i]);
            tick(1);
            rd_chk(OFS_RECORD_DSP_SETUP, sr[i]);
            `CHK(setup, sr[i])
            `CHK(custom, sc[i])
            `CHK(bq, sb[i])
        end
        wr(8'h73, 8'h55);
        rd_chk(8'h73, 8'h00);
        rd_chk(OFS_RECORD_DSP_SETUP, 8'h38);
        // Ramp enabled: level walks, then settles on target
        vol[1] = 8'hcd;
        tick(3);
        `CHK(ramping[1], 1'b1)
        `CHK(lvl[1] !== 8'hcd, 1'b1)
        tick(8 * STEP + 10);
        `CHK(lvl[1], 8'hcd)
        `CHK(ramping[1], 1'b0)
        wr(OFS_RECORD_DSP_SETUP, 8'h3a);
        vol[1] = 8'h10;
        tick(2);
        `CHK(lvl[1], 8'h10)
        // Tie with channel 1 itself inactive
        wr(OFS_RECORD_DSP_SETUP, 8'h3b);
        vol[0] = 8'h40;
        act    = 4'b1010;
        tick(3);
        `CHK(lvl[1], 8'h40)
        `CHK(lvl[3], 8'h40)
        wr(OFS_RECORD_DSP_SETUP, 8'h3a);
        tick(3);
        `CHK(lvl[1], 8'h10)
        `CHK(lvl[3], 8'hc9)
        // Second reset restores the documented values
        i_reset_n = 1'b0;
        tick(2);
        i_reset_n = 1'b1;
        rd_chk(OFS_PLAYBACK_CH2B_VOLUME, 8'hc9);
        rd_chk(OFS_RECORD_DSP_SETUP, 8'h18);
        wrap_up();
    end

    // Whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge i_ref_clk);
        error_cnt++;
        wrap_up();
    end
endmodule

bind codec_gain_and_dsp_config codec_cfg_sva i_sva (
    .i_ref_clk              (i_ref_clk),
    .i_reset_n              (i_reset_n),
    .i_host_req             (i_host_req),
    .o_rd_data              (o_rd_data),
    .o_rd_valid             (o_rd_valid),
    .o_ch2b_mute            (o_ch2b_mute),
    .o_ch2b_gain_half_db    (o_ch2b_gain_half_db),
    .o_ch2b_trim_tenth_db   (o_ch2b_trim_tenth_db),
    .o_record_setup         (o_record_setup),
    .o_highpass_custom      (o_highpass_custom),
    .o_record_biquad_enable (o_record_biquad_enable),
    .o_record_digital_level (o_record_digital_level),
    .o_record_ramping       (o_record_ramping)
);

// file: logic/codec_cfg_pkg.sv
// Constants, field layouts and carriers for the codec gain and DSP setup bank
package codec_cfg_pkg;

    // Register offsets on the host control port
    localparam logic [7:0] OFS_PLAYBACK_CH2B_VOLUME = 8'h70;
    localparam logic [7:0] OFS_PLAYBACK_CH2B_TRIM   = 8'h71;
    localparam logic [7:0] OFS_RECORD_DSP_SETUP     = 8'h72;

    // Values after reset
    localparam logic [7:0] RST_PLAYBACK_CH2B_VOLUME = 8'hc9;
    localparam logic [7:0] RST_PLAYBACK_CH2B_TRIM   = 8'h80;
    localparam logic [7:0] RST_RECORD_DSP_SETUP     = 8'h18;

    // Field positions
    localparam int TRIM_LSB        = 4;
    localparam int DECIM_LSB       = 6;
    localparam int HIGHPASS_LSB    = 4;
    localparam int BIQUAD_LSB      = 2;
    localparam int RAMP_BYPASS_BIT = 1;
    localparam int VOLUME_TIE_BIT  = 0;

    // Volume scale: gain in 0.5 dB units is code minus the unity code
    localparam logic [7:0] VOLUME_MUTE_CODE  = 8'h00;
    localparam logic [7:0] VOLUME_UNITY_CODE = 8'hc9;
    // Fine trim: gain in 0.1 dB units is code minus the neutral code
    localparam logic [3:0] TRIM_NEUTRAL_CODE = 4'h8;
    localparam logic [3:0] TRIM_RESERVED_LOW = 4'h0;

    // Decimation responses
    localparam logic [1:0] DECIM_LINEAR    = 2'h0;
    localparam logic [1:0] DECIM_LOW_LAT   = 2'h1;
    localparam logic [1:0] DECIM_ULTRA_LOW = 2'h2;
    localparam logic [1:0] DECIM_FORBIDDEN = 2'h3;

    // High-pass choices
    localparam logic [1:0] HIGHPASS_CUSTOM_IIR = 2'h0;

    // Gain ramp: one volume code per step interval
    localparam int CLOCK_PERIOD_NS   = 10;
    localparam int RAMP_STEP_TIME_NS = 1000;
    localparam int RAMP_STEP_CYCLES  =
        (RAMP_STEP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    localparam int RECORD_CHANNELS = 4;

    // Record DSP setup fields, in register bit order
    typedef struct packed {
        logic [1:0] record_decim_response;
        logic [1:0] record_highpass_choice;
        logic [1:0] record_biquad_count;
        logic       ramp_bypass;
        logic       record_volume_tie;
    } record_dsp_setup_t;

    // Host control port request
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wr_data;
    } host_req_t;

endpackage

// file: logic/codec_gain_and_dsp_config.sv
// Channel 2B playback gain and record DSP setup register bank
`timescale 1ns/1ps

// How it works
// - Volume code zero mutes channel 2B outright.
// - Codes one and two give -100 dB and -99.5 dB.
// - Code 201 is 0 dB, 202 is +0.5 dB, and the volume resets to 201.
// - Codes 254 and 255 give +26.5 dB and +27 dB.
// - The fine trim sits in bits 7 to 4 and resets to 8, meaning 0 dB.
// - Trim codes 0 to 15 span -0.8 dB to +0.7 dB in 0.1 dB steps.
// - Decimation response is linear, low or ultra-low latency; 3 unused.
// - High-pass choice zero selects the custom IIR stage, all-pass.
// - Choices 1 to 3 are fixed cutoffs, and choice 1 is the reset one.
// - The biquad count runs from zero to three and resets to two.
// - Record gain ramps unless the bypass bit, reset clear, is set.
// - With the tie bit set every active record channel uses channel 1.
module codec_gain_and_dsp_config
    import codec_cfg_pkg::*;
#(
    parameter int STEP_CYCLES = RAMP_STEP_CYCLES
)
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset_n,
    // Host control port
    input  wire host_req_t   i_host_req,
    output logic      [7:0]  o_rd_data,
    output logic             o_rd_valid,
    // Record channel volumes from the neighbouring registers
    input  wire logic [RECORD_CHANNELS-1:0][7:0] i_record_per_channel_volume,
    input  wire logic [RECORD_CHANNELS-1:0]      i_record_channel_active,
    // Playback channel 2B gain
    output logic             o_ch2b_mute,
    output logic signed [8:0] o_ch2b_gain_half_db,
    output logic signed [4:0] o_ch2b_trim_tenth_db,
    // Record DSP setup
    output record_dsp_setup_t o_record_setup,
    output logic             o_highpass_custom,
    output logic      [2:0]  o_record_biquad_enable,
    output logic [RECORD_CHANNELS-1:0][7:0] o_record_digital_level,
    output logic [RECORD_CHANNELS-1:0]      o_record_ramping
);

    // Elaboration check on the ramp step length
    if (STEP_CYCLES < 1)
    begin : g_bad_step
        $error("codec_gain_and_dsp_config: STEP_CYCLES below 1");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0]        volume_r, volume_nxt;
    logic [3:0]        trim_r, trim_nxt;
    record_dsp_setup_t setup_r, setup_nxt;
    logic [7:0]        rd_data_r, rd_data_nxt;
    logic              rd_valid_r, rd_valid_nxt;
    record_dsp_setup_t setup_wr;

    always_comb
    begin
        volume_nxt   = volume_r;
        trim_nxt     = trim_r;
        setup_nxt    = setup_r;
        setup_wr     = record_dsp_setup_t'(i_host_req.wr_data);
        rd_valid_nxt = i_host_req.rd_en;
        rd_data_nxt  = rd_data_r;
        if (i_host_req.wr_en)
        begin
            case (i_host_req.addr)
                OFS_PLAYBACK_CH2B_VOLUME:
                    volume_nxt = i_host_req.wr_data;
                OFS_PLAYBACK_CH2B_TRIM:
                    trim_nxt = i_host_req.wr_data[7:TRIM_LSB];
                OFS_RECORD_DSP_SETUP:
                begin
                    setup_nxt = setup_wr;
                    if (setup_wr.record_decim_response == DECIM_FORBIDDEN)
                        setup_nxt.record_decim_response =
                            setup_r.record_decim_response;
                end
                default:
                    volume_nxt = volume_r;
            endcase
        end
        if (i_host_req.rd_en)
        begin
            case (i_host_req.addr)
                OFS_PLAYBACK_CH2B_VOLUME:
                    rd_data_nxt = volume_r;
                OFS_PLAYBACK_CH2B_TRIM:
                    rd_data_nxt = {trim_r, TRIM_RESERVED_LOW};
                OFS_RECORD_DSP_SETUP:
                    rd_data_nxt = setup_r;
                default:
                    rd_data_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            volume_r   <= RST_PLAYBACK_CH2B_VOLUME;
            trim_r     <= RST_PLAYBACK_CH2B_TRIM[7:TRIM_LSB];
            setup_r    <= record_dsp_setup_t'(RST_RECORD_DSP_SETUP);
            rd_data_r  <= 8'h00;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            volume_r   <= volume_nxt;
            trim_r     <= trim_nxt;
            setup_r    <= setup_nxt;
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Playback channel 2B gain decode
    logic              mute_r, mute_nxt;
    logic signed [8:0] gain_r, gain_nxt;
    logic signed [4:0] trim_db_r, trim_db_nxt;

    always_comb
    begin
        // code zero is a hard mute
        mute_nxt = (volume_r == VOLUME_MUTE_CODE);
        // linear half-dB scale, code 201 at 0 dB
        // ends of scale follow from it
        gain_nxt = mute_nxt ? 9'sh000 :
                   $signed({1'b0, volume_r}) -
                   $signed({1'b0, VOLUME_UNITY_CODE});
        trim_db_nxt = $signed({1'b0, trim_r}) -
                      $signed({1'b0, TRIM_NEUTRAL_CODE});
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mute_r    <= 1'b0;
            gain_r    <= 9'sh000;
            trim_db_r <= 5'sh00;
        end
        else
        begin
            mute_r    <= mute_nxt;
            gain_r    <= gain_nxt;
            trim_db_r <= trim_db_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Record filter selection decode
    logic       custom_r, custom_nxt;
    logic [2:0] biquad_en_r, biquad_en_nxt;

    always_comb
    begin
        custom_nxt = (setup_r.record_highpass_choice == HIGHPASS_CUSTOM_IIR);
        case (setup_r.record_biquad_count)
            2'h0:    biquad_en_nxt = 3'h0;
            2'h1:    biquad_en_nxt = 3'h1;
            2'h2:    biquad_en_nxt = 3'h3;
            default: biquad_en_nxt = 3'h7;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            custom_r    <= 1'b0;
            biquad_en_r <= 3'h3;
        end
        else
        begin
            custom_r    <= custom_nxt;
            biquad_en_r <= biquad_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Record volume targets and ramps
    logic [RECORD_CHANNELS-1:0][7:0] target;

    always_comb
    begin
        for (int ch = 0; ch < RECORD_CHANNELS; ch++)
        begin
            // tie to channel 1 when active
            if (setup_r.record_volume_tie && i_record_channel_active[ch])
                target[ch] = i_record_per_channel_volume[0];
            else
                target[ch] = i_record_per_channel_volume[ch];
        end
    end

    for (genvar ch = 0; ch < RECORD_CHANNELS; ch++)
    begin : g_ramp
        gain_ramp #(
            .STEP_CYCLES (STEP_CYCLES)
        ) u_ramp (
            .i_ref_clk     (i_ref_clk),
            .i_reset_n     (i_reset_n),
            .i_target      (target[ch]),
            .i_reset_level (RST_PLAYBACK_CH2B_VOLUME),
            .i_bypass      (setup_r.ramp_bypass),
            .o_level       (o_record_digital_level[ch]),
            .o_moving      (o_record_ramping[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_rd_data              = rd_data_r;
    assign o_rd_valid             = rd_valid_r;
    assign o_ch2b_mute            = mute_r;
    assign o_ch2b_gain_half_db    = gain_r;
    assign o_ch2b_trim_tenth_db   = trim_db_r;
    assign o_record_setup         = setup_r;
    assign o_highpass_custom      = custom_r;
    assign o_record_biquad_enable = biquad_en_r;

endmodule

// file: logic/gain_ramp.sv
// Soft-stepping volume follower for one channel
`timescale 1ns/1ps

module gain_ramp
    import codec_cfg_pkg::*;
#(
    parameter int STEP_CYCLES = RAMP_STEP_CYCLES
)
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    // Control
    input  wire logic [7:0] i_target,
    input  wire logic [7:0] i_reset_level,
    input  wire logic       i_bypass,
    // Applied level
    output logic      [7:0] o_level,
    output logic            o_moving
);

    // Elaboration check: a zero-length step has no counter to serve it
    if (STEP_CYCLES < 1)
    begin : g_bad_step
        $error("gain_ramp: STEP_CYCLES must be at least 1");
    end

    typedef enum logic [1:0] {
        RAMP_IDLE = 2'b01,
        RAMP_MOVE = 2'b10
    } ramp_state_t;

    localparam int CW = $clog2(STEP_CYCLES + 1);
    localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

    ramp_state_t   state_r, state_nxt;
    logic [7:0]    level_r, level_nxt;
    logic [CW-1:0] count_r, count_nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_nxt = state_r;
        level_nxt = level_r;
        count_nxt = count_r;
        if (i_bypass)
        begin
            // Bypass jumps straight to the target
            state_nxt = RAMP_IDLE;
            level_nxt = i_target;
            count_nxt = '0;
        end
        else
        begin
            case (state_r)
                RAMP_IDLE:
                begin
                    count_nxt = '0;
                    if (level_r != i_target)
                        state_nxt = RAMP_MOVE;
                end
                RAMP_MOVE:
                begin
                    if (level_r == i_target)
                        state_nxt = RAMP_IDLE;
                    else if (count_r == STEP_LAST)
                    begin
                        // One code is 0.5 dB: small enough to be inaudible
                        count_nxt = '0;
                        level_nxt = (level_r < i_target) ?
                                    level_r + 8'h01 : level_r - 8'h01;
                    end
                    else
                        count_nxt = count_r + CW'(1);
                end
                default:
                begin
                    state_nxt = RAMP_IDLE;
                    count_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r <= RAMP_IDLE;
            level_r <= RST_PLAYBACK_CH2B_VOLUME;
            count_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            level_r <= level_nxt;
            count_r <= count_nxt;
        end
    end

    assign o_level  = level_r;
    // One-hot: bit 1 is the move state, so the flag is a plain flop
    assign o_moving = state_r[1];

endmodule
